/* File: hw/pib_irq_bank.sv */
// Top of the peripheral interrupt enable bank: six enable registers,
// peripheral gate, onward request, and a small event interrupt.
// Assumes flag inputs come from peripheral logic on the same clock.
//
// Overview of operation
// [RQ1] Second bank bit 6 gates zero-cross interrupt
// [RQ2] Second bank bits 1,0 gate comparators
// [RQ3] Third bank: serial ports, synchronous ports
// [RQ4] Fourth bank: timer two match, timer one overflow
// [RQ5] Banked interrupts also need the peripheral gate
// [RQ6] Fifth bank: logic cells, timer one gate
// [RQ7] Sixth bank: capture/compare two, one
// [RQ8] Seventh bank: memory done, oscillator, waveform
// [RQ9] Enables read/write, zero after every reset
// [RQ10] Unimplemented bits read zero, ignore writes
// [RQ11] Flags stand regardless of any enable
// [RQ12] Peripheral gate allows or blocks all
// [RQ13] Request is OR of flag AND enable, gated
`timescale 1ns/100ps
module pib_irq_bank (
	// Clock, reset, enable
	input  wire  logic       clock,
	input  wire  logic       rst_n,
	input  wire  logic       ce,
	// Register port
	input  wire  logic [3:0] addr,
	input  wire  logic [7:0] wr_data,
	input  wire  logic       wr_en,
	input  wire  logic       rd_en,
	output logic       [7:0] rd_data,
	// Peripheral flags
	input  wire  logic [7:0] flags_bank_two,
	input  wire  logic [7:0] flags_bank_three,
	input  wire  logic [7:0] flags_bank_four,
	input  wire  logic [7:0] flags_bank_five,
	input  wire  logic [7:0] flags_bank_six,
	input  wire  logic [7:0] flags_bank_seven,
	// Requests
	output logic             periph_irq_req,
	output logic             irq
);

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	function automatic logic bank_hit(input logic [3:0] a, input logic [3:0] base, input int unsigned idx);
		bank_hit = (a == (base + 4'(idx)));
	endfunction : bank_hit

	function automatic logic [7:0] bank_pending(input logic [7:0] f, input logic [7:0] e);
		bank_pending = f & e;
	endfunction : bank_pending

	function automatic logic [7:0] read_select(
		input logic [3:0]      a,
		input logic [5:0][7:0] e,
		input logic [5:0][7:0] f,
		input logic [7:0]      ctl,
		input logic [1:0]      st,
		input logic [1:0]      msk,
		input logic [5:0]      pv
	);
		read_select = 8'h00;
		for (int unsigned i = 0; i < pib_pkg::NUM_BANKS; i++)
		begin
			if (bank_hit(a, pib_pkg::ADDR_EN_BASE, i))
			begin
				read_select = e[i];
			end
			if (bank_hit(a, pib_pkg::ADDR_FLAG_BASE, i))
			begin
				read_select = f[i];
			end
		end
		case (a)
			pib_pkg::ADDR_CTRL:   read_select = ctl;
			pib_pkg::ADDR_STATUS: read_select = {6'h00, st};
			pib_pkg::ADDR_MASK:   read_select = {6'h00, msk};
			pib_pkg::ADDR_PEND:   read_select = {2'h0, pv};
			default:              read_select = read_select;
		endcase
	endfunction : read_select

	// Flags and enables as bank arrays
	wire logic [5:0][7:0] flags;
	wire logic [5:0][7:0] en_bank;
	wire logic [5:0]      bank_wr;
	wire logic [5:0]      pend_vec;

	assign flags = {flags_bank_seven, flags_bank_six, flags_bank_five,
		flags_bank_four, flags_bank_three, flags_bank_two};

	genvar g;
	generate
		for (g = 0; g < 6; g++)
		begin : gen_bank
			assign bank_wr[g] = wr_en && bank_hit(addr, pib_pkg::ADDR_EN_BASE, g);
			assign pend_vec[g] = |bank_pending(flags[g], en_bank[g]); // [RQ13]

			pib_enable_reg #(
				.IMPL_MASK (pib_pkg::IMPL_MASKS[g])
			) u_en (
				.clock   (clock),
				.rst_n   (rst_n),
				.ce      (ce),
				.wr_en   (bank_wr[g]),
				.wr_data (wr_data),
				.en      (en_bank[g])
			); // [RQ1] [RQ2] [RQ3] [RQ4] [RQ6] [RQ7] [RQ8]
		end
	endgenerate

	// Control, status and mask
	logic [7:0] ctrl;
	logic [1:0] status;
	logic [1:0] mask;
	logic       blocked_prev;

	wire logic       gate;
	wire logic       any_pending;
	wire logic       next_req;
	wire logic       ctrl_wr;
	wire logic       mask_wr;
	wire logic       status_rd;
	wire logic       blocked_now;
	wire logic [1:0] status_set;
	wire logic [1:0] next_status;
	wire logic [1:0] next_mask;
	wire logic       next_irq;
	wire logic [7:0] rd_mux;

	assign gate        = ctrl[pib_pkg::PERIPHERAL_IRQ_GATE_BIT];
	assign any_pending = |pend_vec; // [RQ13]
	assign next_req    = any_pending && gate; // [RQ5] [RQ12]
	assign ctrl_wr     = wr_en && (addr == pib_pkg::ADDR_CTRL);
	assign mask_wr     = wr_en && (addr == pib_pkg::ADDR_MASK);
	assign status_rd   = rd_en && (addr == pib_pkg::ADDR_STATUS);
	assign blocked_now = any_pending && !gate;

	assign status_set[pib_pkg::STAT_REQ_RISE_BIT] = next_req && !periph_irq_req;
	assign status_set[pib_pkg::STAT_BLOCKED_BIT]  = blocked_now && !blocked_prev;
	// Set beats read-clear in the same cycle
	assign next_status = (status & ~{2{status_rd}}) | status_set;
	// New mask counts at once, so irq never lags a mask write
	assign next_mask   = mask_wr ? wr_data[1:0] : mask;
	assign next_irq    = |(next_status & next_mask);

	// Flag views are raw inputs, independent of enables
	assign rd_mux = read_select(addr, en_bank, flags, ctrl, status, mask, pend_vec); // [RQ11] [RQ10]

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl <= pib_pkg::CTRL_RESET;
			mask <= pib_pkg::MASK_RESET;
		end
		else if (ce)
		begin
			if (ctrl_wr)
			begin
				ctrl <= {7'h00, wr_data[pib_pkg::PERIPHERAL_IRQ_GATE_BIT]}; // [RQ10]
			end
			mask <= next_mask;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status       <= pib_pkg::STATUS_RESET;
			blocked_prev <= 1'b0;
			irq          <= 1'b0;
		end
		else if (ce)
		begin
			status       <= next_status;
			blocked_prev <= blocked_now;
			irq          <= next_irq;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			periph_irq_req <= 1'b0;
		end
		else if (ce)
		begin
			periph_irq_req <= next_req; // [RQ13]
		end
	end

	// Read data valid only the cycle after the strobe
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_data <= 8'h00;
		end
		else if (ce)
		begin
			rd_data <= rd_en ? rd_mux : 8'h00;
		end
	end

	a_zero_cross_gate : assert property ( // [RQ1]
		ce && gate && flags[0][pib_pkg::ZERO_CROSS_IRQ_EN_BIT]
		&& en_bank[0][pib_pkg::ZERO_CROSS_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("zero-cross interrupt not forwarded");

	a_comparator_gate : assert property ( // [RQ2]
		ce && gate && flags[0][pib_pkg::COMPARATOR_ONE_IRQ_EN_BIT]
		&& en_bank[0][pib_pkg::COMPARATOR_ONE_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("comparator interrupt not forwarded");

	a_comparator_two_gate : assert property ( // [RQ2]
		ce && gate && flags[0][pib_pkg::COMPARATOR_TWO_IRQ_EN_BIT]
		&& en_bank[0][pib_pkg::COMPARATOR_TWO_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("second comparator interrupt not forwarded");

	a_serial_rx_gate : assert property ( // [RQ3]
		ce && gate && flags[1][pib_pkg::SERIAL_TWO_RX_IRQ_EN_BIT]
		&& en_bank[1][pib_pkg::SERIAL_TWO_RX_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("serial receive interrupt not forwarded");

	a_sync_done_gate : assert property ( // [RQ3]
		ce && gate && flags[1][pib_pkg::SYNC_ONE_DONE_IRQ_EN_BIT]
		&& en_bank[1][pib_pkg::SYNC_ONE_DONE_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("synchronous port interrupt not forwarded");

	a_bank_three_rw : assert property ( // [RQ3]
		ce && wr_en && addr == 4'h1
		##1 ce && rd_en && addr == 4'h1 |=> rd_data == $past(wr_data, 2))
		else $error("third bank readback wrong");

	a_timer_match_gate : assert property ( // [RQ4]
		ce && gate && flags[2][pib_pkg::TIMER_TWO_MATCH_IRQ_EN_BIT]
		&& en_bank[2][pib_pkg::TIMER_TWO_MATCH_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("timer two match not forwarded");

	a_timer_ovf_gate : assert property ( // [RQ4]
		ce && gate && flags[2][pib_pkg::TIMER_ONE_OVERFLOW_IRQ_EN_BIT]
		&& en_bank[2][pib_pkg::TIMER_ONE_OVERFLOW_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("timer one overflow not forwarded");

	a_logic_cell_gate : assert property ( // [RQ6]
		ce && gate && flags[3][pib_pkg::LOGIC_CELL_FOUR_IRQ_EN_BIT]
		&& en_bank[3][pib_pkg::LOGIC_CELL_FOUR_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("logic cell interrupt not forwarded");

	a_timer_gate_src : assert property ( // [RQ6]
		ce && gate && flags[3][pib_pkg::TIMER_ONE_GATE_IRQ_EN_BIT]
		&& en_bank[3][pib_pkg::TIMER_ONE_GATE_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("timer gate interrupt not forwarded");

	a_gate_blocks_all : assert property ( // [RQ5]
		ce && !gate |=> !periph_irq_req)
		else $error("request while peripheral gate clear");

	a_bank_five_layout : assert property ( // [RQ6]
		en_bank[3][3:1] == 3'b000)
		else $error("fifth bank reserved bits set");

	a_bank_six_layout : assert property ( // [RQ7]
		en_bank[4][7:2] == 6'h00)
		else $error("sixth bank reserved bits set");

	a_nvm_done_gate : assert property ( // [RQ8]
		ce && gate && flags[5][pib_pkg::NVM_DONE_IRQ_EN_BIT]
		&& en_bank[5][pib_pkg::NVM_DONE_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("memory done interrupt not forwarded");

	a_capcomp_gate : assert property ( // [RQ7]
		ce && gate && flags[4][pib_pkg::CAPCOMP_TWO_IRQ_EN_BIT]
		&& en_bank[4][pib_pkg::CAPCOMP_TWO_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("capture compare interrupt not forwarded");

	a_osc_rollover_gate : assert property ( // [RQ8]
		ce && gate && flags[5][pib_pkg::OSC_ROLLOVER_IRQ_EN_BIT]
		&& en_bank[5][pib_pkg::OSC_ROLLOVER_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("oscillator rollover not forwarded");

	a_waveform_gate : assert property ( // [RQ8]
		ce && gate && flags[5][pib_pkg::WAVEFORM_GEN_IRQ_EN_BIT]
		&& en_bank[5][pib_pkg::WAVEFORM_GEN_IRQ_EN_BIT] |=> periph_irq_req)
		else $error("waveform interrupt not forwarded");

	a_reset_clears_en : assert property ( // [RQ9]
		$rose(rst_n) |-> (en_bank == '0 && ctrl == 8'h00))
		else $error("enables not zero after reset");

	a_en_write_lands : assert property ( // [RQ9]
		ce && wr_en && addr == pib_pkg::ADDR_EN_BASE
		|=> en_bank[0] == ($past(wr_data) & pib_pkg::IMPL_BANK_TWO))
		else $error("second bank write lost");

	a_unmapped_bits_read : assert property ( // [RQ10]
		ce && rd_en && addr == 4'h2 |=> rd_data[7:2] == 6'h00)
		else $error("fourth bank reserved bits read set");

	a_flag_view_raw : assert property ( // [RQ11]
		ce && rd_en && addr == pib_pkg::ADDR_FLAG_BASE |=> rd_data == $past(flags_bank_two))
		else $error("flag view depends on enables");

	a_idle_no_req : assert property ( // [RQ13]
		ce && !any_pending ##1 ce && !any_pending |-> !periph_irq_req)
		else $error("request without pending source");

	a_gate_open_req : assert property ( // [RQ12]
		ce && gate && any_pending |=> periph_irq_req)
		else $error("gate open but request low");

	a_irq_from_status : assert property (
		ce && |(status_set & next_mask) |=> irq && status != 2'h0)
		else $error("masked event did not raise irq");

	a_irq_tracks_status : assert property (
		ce |=> irq == |(status & mask))
		else $error("irq differs from unmasked status");

	a_blocked_sets_status : assert property (
		ce && status_set[pib_pkg::STAT_BLOCKED_BIT] |=> status[pib_pkg::STAT_BLOCKED_BIT])
		else $error("blocked event not recorded");

	a_status_read_clear : assert property (
		ce && status_rd && status_set == 2'h0 |=> status == 2'h0)
		else $error("status not cleared by read");

	a_rd_data_idle : assert property (
		ce && !rd_en |=> rd_data == 8'h00)
		else $error("read data outside read cycle");

	a_ce_freezes_out : assert property (
		!ce |=> $stable(periph_irq_req) && $stable(irq) && $stable(rd_data) && $stable(en_bank))
		else $error("state moved while clock enable low");

	c_req_rise : cover property (ce && !periph_irq_req ##1 periph_irq_req);
	c_status_clear : cover property (status != 2'h0 && status_rd && ce ##1 status == 2'h0);
	c_blocked_event : cover property (ce && status_set[pib_pkg::STAT_BLOCKED_BIT]);
	c_irq_high : cover property (irq);
	c_ce_hold : cover property (!ce ##1 ce);

endmodule : pib_irq_bank

/* File: hw/pib_pkg.sv */
// Constants shared by the peripheral interrupt enable bank.
// Assumes a single system clock and an 8-bit register port.
package pib_pkg;

	localparam int unsigned DATA_W    = 8;
	localparam int unsigned ADDR_W    = 4;
	localparam int unsigned NUM_BANKS = 6;
	localparam int unsigned STATUS_W  = 2;

	// Register addresses
	localparam logic [3:0] ADDR_EN_BASE   = 4'h0;
	localparam logic [3:0] ADDR_CTRL      = 4'h6;
	localparam logic [3:0] ADDR_STATUS    = 4'h7;
	localparam logic [3:0] ADDR_MASK      = 4'h8;
	localparam logic [3:0] ADDR_FLAG_BASE = 4'h9;
	localparam logic [3:0] ADDR_PEND      = 4'hf;

	// Implemented enable bits per bank
	localparam logic [7:0] IMPL_BANK_TWO   = 8'h43;
	localparam logic [7:0] IMPL_BANK_THREE = 8'hff;
	localparam logic [7:0] IMPL_BANK_FOUR  = 8'h03;
	localparam logic [7:0] IMPL_BANK_FIVE  = 8'hf1;
	localparam logic [7:0] IMPL_BANK_SIX   = 8'h03;
	localparam logic [7:0] IMPL_BANK_SEVEN = 8'h31;
	localparam logic [5:0][7:0] IMPL_MASKS = {IMPL_BANK_SEVEN, IMPL_BANK_SIX, IMPL_BANK_FIVE,
		IMPL_BANK_FOUR, IMPL_BANK_THREE, IMPL_BANK_TWO};

	// Field positions, second bank
	localparam int unsigned ZERO_CROSS_IRQ_EN_BIT     = 6;
	localparam int unsigned COMPARATOR_TWO_IRQ_EN_BIT = 1;
	localparam int unsigned COMPARATOR_ONE_IRQ_EN_BIT = 0;
	// Field positions, third bank
	localparam int unsigned SERIAL_TWO_RX_IRQ_EN_BIT      = 7;
	localparam int unsigned SERIAL_TWO_TX_IRQ_EN_BIT      = 6;
	localparam int unsigned SERIAL_ONE_RX_IRQ_EN_BIT      = 5;
	localparam int unsigned SERIAL_ONE_TX_IRQ_EN_BIT      = 4;
	localparam int unsigned SYNC_TWO_COLLISION_IRQ_EN_BIT = 3;
	localparam int unsigned SYNC_TWO_DONE_IRQ_EN_BIT      = 2;
	localparam int unsigned SYNC_ONE_COLLISION_IRQ_EN_BIT = 1;
	localparam int unsigned SYNC_ONE_DONE_IRQ_EN_BIT      = 0;
	// Field positions, fourth to seventh banks
	localparam int unsigned TIMER_TWO_MATCH_IRQ_EN_BIT    = 1;
	localparam int unsigned TIMER_ONE_OVERFLOW_IRQ_EN_BIT = 0;
	localparam int unsigned LOGIC_CELL_FOUR_IRQ_EN_BIT    = 7;
	localparam int unsigned LOGIC_CELL_ONE_IRQ_EN_BIT     = 4;
	localparam int unsigned TIMER_ONE_GATE_IRQ_EN_BIT     = 0;
	localparam int unsigned CAPCOMP_TWO_IRQ_EN_BIT        = 1;
	localparam int unsigned CAPCOMP_ONE_IRQ_EN_BIT        = 0;
	localparam int unsigned NVM_DONE_IRQ_EN_BIT           = 5;
	localparam int unsigned OSC_ROLLOVER_IRQ_EN_BIT       = 4;
	localparam int unsigned WAVEFORM_GEN_IRQ_EN_BIT       = 0;

	// Control and status fields
	localparam int unsigned PERIPHERAL_IRQ_GATE_BIT = 0;
	localparam int unsigned STAT_REQ_RISE_BIT       = 0;
	localparam int unsigned STAT_BLOCKED_BIT        = 1;

	// Reset values
	localparam logic [7:0] EN_RESET     = 8'h00;
	localparam logic [7:0] CTRL_RESET   = 8'h00;
	localparam logic [1:0] STATUS_RESET = 2'h0;
	localparam logic [1:0] MASK_RESET   = 2'h0;

endpackage : pib_pkg

/* File: hw/pib_enable_reg.sv */
// One 8-bit interrupt enable register with unimplemented bits held low.
// Assumes write strobe and data come from logic on the same clock.
`timescale 1ns/100ps
module pib_enable_reg #(
	parameter logic [7:0] IMPL_MASK = 8'hff
) (
	// Clock, reset and enable
	input  wire  logic       clock,
	input  wire  logic       rst_n,
	input  wire  logic       ce,
	// Write side
	input  wire  logic       wr_en,
	input  wire  logic [7:0] wr_data,
	// Stored enables
	output logic       [7:0] en
);

	wire logic [7:0] next_en;

	// Writes to unimplemented positions are dropped
	assign next_en = wr_data & IMPL_MASK; // [RQ10]

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			en <= pib_pkg::EN_RESET; // [RQ9]
		end
		else if (ce && wr_en)
		begin
			en <= next_en; // [RQ9]
		end
	end

	a_unimpl_stay_zero : assert property (@(posedge clock) disable iff (!rst_n) // [RQ10]
		(en & ~IMPL_MASK) == 8'h00)
		else $error("unimplemented enable bit set");

endmodule : pib_enable_reg

/* File: verif/pib_flag_model.sv */
// Behavioural model of the peripheral blocks that raise interrupt flags.
// Assumes the bench hands it a new flag pattern with a one-cycle load pulse.
`timescale 1ns/100ps
module pib_flag_model (
	// Clock and reset
	input  wire  logic            clock,
	input  wire  logic            rst_n,
	// Bench control
	input  wire  logic            load,
	input  wire  logic [5:0][7:0] pattern,
	// Flags toward the bank
	output logic       [5:0][7:0] flags
);
	// Flags are levels owned here; no enable or gate touches them
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			flags <= '0;
		else if (load)
			flags <= pattern;
	end
endmodule : pib_flag_model

/* File: verif/pib_irq_bank_tb.sv */
// Self-checking bench for the peripheral interrupt enable bank.
// Assumes the flag model stands in for the peripherals.
`timescale 1ns/100ps
module pib_irq_bank_tb;
	logic            clock;
	logic            rst_n;
	logic            ce;
	logic [3:0]      addr;
	logic [7:0]      wr_data;
	logic            wr_en;
	logic            rd_en;
	logic [7:0]      rd_data;
	logic            load;
	logic [5:0][7:0] pattern;
	logic [5:0][7:0] flags;
	logic [5:0][7:0] pr;
	logic            periph_irq_req;
	logic            irq;
	logic [7:0]      exp_q[$];
	logic [7:0]      en_m[6];
	logic            rd_seen;
	logic            gate;
	logic            exp_req;
	logic [7:0]      exp_pend;
	int              error_cnt;
	int              n_compared;
	int              seed;

	pib_flag_model u_pib_flag_model (
		.clock   (clock),
		.rst_n   (rst_n),
		.load    (load),
		.pattern (pattern),
		.flags   (flags)
	);

	pib_irq_bank u_pib_irq_bank (
		.clock            (clock),
		.rst_n            (rst_n),
		.ce               (ce),
		.addr             (addr),
		.wr_data          (wr_data),
		.wr_en            (wr_en),
		.rd_en            (rd_en),
		.rd_data          (rd_data),
		.flags_bank_two   (flags[0]),
		.flags_bank_three (flags[1]),
		.flags_bank_four  (flags[2]),
		.flags_bank_five  (flags[3]),
		.flags_bank_six   (flags[4]),
		.flags_bank_seven (flags[5]),
		.periph_irq_req   (periph_irq_req),
		.irq              (irq)
	);

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic give_verdict();
		if (error_cnt == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		rd_en   <= 1'b0;
	endtask : wr

	// Read note goes on the queue; the watcher compares it
	task automatic rd(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr  <= a;
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		exp_q.push_back(d);
	endtask : rd

	task automatic idle(input int n);
		repeat (n)
		begin
			@(posedge clock);
			wr_en <= 1'b0;
			rd_en <= 1'b0;
			load  <= 1'b0;
		end
	endtask : idle

	task automatic set_flags(input logic [5:0][7:0] p);
		@(posedge clock);
		wr_en   <= 1'b0;
		rd_en   <= 1'b0;
		pattern <= p;
		load    <= 1'b1;
		idle(1);
	endtask : set_flags

	// Read data stand only in the cycle after the strobe
	always @(posedge clock)
	begin
		rd_seen <= rd_en & rst_n;
		if (rd_seen)
			chk("rd_data", rd_data, exp_q.pop_front());
	end

	initial
	begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		give_verdict();
	end

	initial
	begin
		seed    = 32'ha84646f5;
		ce      = 1'b1;
		rst_n   = 1'b0;
		addr    = 4'h0;
		wr_data = 8'h00;
		wr_en   = 1'b0;
		rd_en   = 1'b0;
		load    = 1'b0;
		pattern = '0;
		pr      = '0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		for (int b = 0; b < 6; b++)
			rd(b[3:0], 8'h00);
		// Blocked event first, then release by the gate
		wr(pib_pkg::ADDR_MASK, 8'h01);
		rd(pib_pkg::ADDR_MASK, 8'h01);
		wr(pib_pkg::ADDR_EN_BASE, 8'h40);
		pr[0] = 8'h40;
		set_flags(pr);
		idle(3);
		@(negedge clock);
		chk("irq masked", {7'h00, irq}, 8'h00);
		chk("req gated", {7'h00, periph_irq_req}, 8'h00);
		wr(pib_pkg::ADDR_CTRL, 8'h01);
		idle(3);
		@(negedge clock);
		chk("req zero cross", {7'h00, periph_irq_req}, 8'h01);
		chk("irq", {7'h00, irq}, 8'h01);
		rd(pib_pkg::ADDR_STATUS, 8'h03);
		idle(3);
		@(negedge clock);
		chk("irq cleared", {7'h00, irq}, 8'h00);
		// Shut gate with a pending source: blocked event on mask bit 1
		wr(pib_pkg::ADDR_MASK, 8'h02);
		wr(pib_pkg::ADDR_CTRL, 8'h00);
		idle(3);
		@(negedge clock);
		chk("irq blocked event", {7'h00, irq}, 8'h01);
		chk("req gate shut", {7'h00, periph_irq_req}, 8'h00);
		rd(pib_pkg::ADDR_STATUS, 8'h02);
		// All ones, back-to-back write and read
		for (int b = 0; b < 6; b++)
		begin
			wr(b[3:0], 8'hff);
			rd(b[3:0], pib_pkg::IMPL_MASKS[b]);
		end
		for (int i = 0; i < 24; i++)
		begin
			gate = 1'($random(seed));
			wr(pib_pkg::ADDR_CTRL, {7'h00, gate});
			exp_req = 1'b0;
			exp_pend = 8'h00;
			for (int b = 0; b < 6; b++)
			begin
				en_m[b] = 8'($random(seed));
				pr[b]   = 8'($random(seed) & $random(seed) & $random(seed));
				wr(b[3:0], en_m[b]);
				rd(b[3:0], en_m[b] & pib_pkg::IMPL_MASKS[b]);
				exp_req = exp_req | (|(pr[b] & en_m[b] & pib_pkg::IMPL_MASKS[b]));
				exp_pend[b] = |(pr[b] & en_m[b] & pib_pkg::IMPL_MASKS[b]);
			end
			set_flags(pr);
			idle(3);
			@(negedge clock);
			chk("periph_irq_req", {7'h00, periph_irq_req}, {7'h00, gate & exp_req});
			rd(pib_pkg::ADDR_FLAG_BASE + 4'(i % 6), pr[i % 6]);
			rd(pib_pkg::ADDR_PEND, exp_pend);
			rd(pib_pkg::ADDR_CTRL, {7'h00, gate});
		end
		// Clock enable low: the write must be dropped
		idle(1);
		ce <= 1'b0;
		wr(4'h5, ~en_m[5]);
		idle(1);
		ce <= 1'b1;
		rd(4'h5, en_m[5] & pib_pkg::IMPL_MASKS[5]);
		// Reset in mid-run clears the enables again
		idle(2);
		rst_n <= 1'b0;
		idle(2);
		rst_n <= 1'b1;
		rd(4'h1, 8'h00);
		idle(3);
		give_verdict();
	end
endmodule : pib_irq_bank_tb
